// ===== hdl/uptu_regs.sv
// unlock key, interrupt pulse width and line test registers of the
// peripheral controller, with the line override they steer
// assumes a single-cycle strobe register port and a transceiver that
// takes the line override in place of its own drive
//
// Behaviour
// - resume locks writes until key aa37 written
// - pulse mode width set by width register
// - width one gives the shortest pulse
// - width register resets to 001e
// - high-speed lock disables chirp detection
// - full-speed lock disables chirp detection
// - random test toggles lines in fixed pattern
// - k bit holds lines in k state
// - j bit holds lines in j state
// - quiet bit holds high-speed idle state
// - quiet test answers high-speed in with nak
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module uptu_regs
  import uptu_pkg::*;
(
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_in,
  // register port
  input  wire logic [uptu_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [uptu_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic [uptu_pkg::DATA_W-1:0]      reg_rdata_out,
  // device events
  input  wire logic                       resume_in,
  input  wire logic                       usb_bus_reset_in,
  input  wire logic                       irq_pulse_mode_in,
  input  wire logic                       irq_req_in,
  output logic                            irq_out,
  output logic                            regs_writable_out,
  // speed control
  output logic                            lock_high_speed_out,
  output logic                            lock_full_speed_out,
  output logic                            chirp_detect_en_out,
  // transceiver normal drive
  input  wire logic                       xcvr_dp_in,
  input  wire logic                       xcvr_dm_in,
  input  wire logic                       xcvr_oe_in,
  // line pins
  output logic                            line_dp_out,
  output logic                            line_dm_out,
  output logic                            line_oe_out,
  output logic                            line_hs_idle_out,
  // high-speed token path
  input  wire logic                       hs_in_token_in,
  output logic                            force_nak_out,
  output logic                            hs_quiet_nak_test_out
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_key;
  logic wr_width;
  logic wr_test;
  logic rd_width;
  logic rd_test;
  logic rd_status;

  assign wr_key    = reg_wr_in && hit(reg_addr_in, OFS_UNLOCK_KEY);
  assign wr_width  = reg_wr_in && hit(reg_addr_in, OFS_IRQ_WIDTH);
  assign wr_test   = reg_wr_in && hit(reg_addr_in, OFS_LINE_TEST);
  assign rd_width  = reg_rd_in && hit(reg_addr_in, OFS_IRQ_WIDTH);
  assign rd_test   = reg_rd_in && hit(reg_addr_in, OFS_LINE_TEST);
  assign rd_status = reg_rd_in && hit(reg_addr_in, OFS_LOCK_STATUS);

  // ****************************************************************
  // write lock
  // ****************************************************************
  logic locked_reg;
  logic locked_next;

  always_comb
  begin
    locked_next = locked_reg;
    // a resume in the same cycle as the key write wins: the key must come after
    if (wr_key && (reg_wdata_in == UNLOCK_KEY_VALUE))
      locked_next = 1'b0;
    if (resume_in)
      locked_next = 1'b1;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      locked_reg <= 1'b0;
    else
      locked_reg <= locked_next;
  end

  assign regs_writable_out = !locked_reg;

  // ****************************************************************
  // interrupt pulse width
  // ****************************************************************
  logic [DATA_W-1:0] irq_width_count_reg;
  logic [DATA_W-1:0] irq_width_count_next;

  always_comb
  begin
    irq_width_count_next = irq_width_count_reg;
    if (wr_width && !locked_reg)
      irq_width_count_next = reg_wdata_in;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_width_count_reg <= IRQ_WIDTH_RESET;
    else
      irq_width_count_reg <= irq_width_count_next;
  end

  // counts in core clock cycles; a value of one is one clock, the shortest
  // pulse this clock can make, so sub-cycle widths round up
  uptu_irq_pulse #(
    .WIDTH_W       (DATA_W)
  ) u_irq_pulse (
    .clk_in        (core_clk_in),
    .rst_in        (rst_in),
    .pulse_mode_in (irq_pulse_mode_in),
    .irq_req_in    (irq_req_in),
    .width_in      (irq_width_count_reg),
    .irq_out       (irq_out)
  );

  // ****************************************************************
  // line test register
  // ****************************************************************
  logic [TEST_W-1:0] test_reg;
  logic [TEST_W-1:0] test_next;

  always_comb
  begin
    test_next = test_reg;
    if (usb_bus_reset_in)
      test_next = test_reg & BUS_RESET_KEEP;
    // reserved bits are stored as written; software keeps them zero
    // only one bit set at a time is software's duty, not checked here
    if (wr_test && !locked_reg)
      test_next = reg_wdata_in[TEST_W-1:0];
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      test_reg <= LINE_TEST_RESET;
    else
      test_reg <= test_next;
  end

  // ****************************************************************
  // speed locks
  // ****************************************************************
  assign lock_high_speed_out = test_reg[TB_LOCK_HS];
  assign lock_full_speed_out = test_reg[TB_LOCK_FS];
  assign chirp_detect_en_out =
    !(test_reg[TB_LOCK_HS] || test_reg[TB_LOCK_FS]);

  // ****************************************************************
  // line override
  // ****************************************************************
  logic random_bit;

  uptu_line_pattern u_line_pattern (
    .clk_in    (core_clk_in),
    .rst_in    (rst_in),
    .enable_in (test_reg[TB_RANDOM]),
    .bit_out   (random_bit)
  );

  logic dp_next;
  logic dm_next;
  logic oe_next;
  logic idle_next;
  logic dp_reg;
  logic dm_reg;
  logic oe_reg;
  logic idle_reg;

  // priority only matters if software breaks the one-bit convention
  always_comb
  begin
    dp_next   = xcvr_dp_in;
    dm_next   = xcvr_dm_in;
    oe_next   = xcvr_oe_in;
    idle_next = 1'b0;
    if (test_reg[TB_QUIET_NAK])
    begin
      dp_next   = 1'b0;
      dm_next   = 1'b0;
      oe_next   = 1'b1;
      idle_next = 1'b1;
    end
    else if (test_reg[TB_DRIVE_J])
    begin
      dp_next = 1'b1;
      dm_next = 1'b0;
      oe_next = 1'b1;
    end
    else if (test_reg[TB_DRIVE_K])
    begin
      dp_next = 1'b0;
      dm_next = 1'b1;
      oe_next = 1'b1;
    end
    else if (test_reg[TB_RANDOM])
    begin
      dp_next = random_bit;
      dm_next = !random_bit;
      oe_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dp_reg   <= 1'b0;
      dm_reg   <= 1'b0;
      oe_reg   <= 1'b0;
      idle_reg <= 1'b0;
    end
    else
    begin
      dp_reg   <= dp_next;
      dm_reg   <= dm_next;
      oe_reg   <= oe_next;
      idle_reg <= idle_next;
    end
  end

  assign line_dp_out      = dp_reg;
  assign line_dm_out      = dm_reg;
  assign line_oe_out      = oe_reg;
  assign line_hs_idle_out = idle_reg;

  // ****************************************************************
  // nak-only answer
  // ****************************************************************
  assign hs_quiet_nak_test_out = test_reg[TB_QUIET_NAK];
  assign force_nak_out = test_reg[TB_QUIET_NAK] && hs_in_token_in;

  // ****************************************************************
  // read data, one cycle after the strobe
  // ****************************************************************
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  always_comb
  begin
    rdata_next = READ_ZERO;
    // the key register is write only and reads as zero
    if (rd_width)
      rdata_next = irq_width_count_reg;
    else if (rd_test)
      rdata_next = {{(DATA_W-TEST_W){1'b0}}, test_reg};
    else if (rd_status)
    begin
      rdata_next = READ_ZERO;
      rdata_next[LOCK_STATUS_BIT] = locked_reg;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_reg <= READ_ZERO;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata_out = rdata_reg;

endmodule

`default_nettype wire

// ===== hdl/uptu_pkg.sv
// package for the peripheral unlock, interrupt pulse width and line test block
// holds register offsets, reset values, field positions and timing figures
package uptu_pkg;

  // ****************************************************************
  // register bus
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_UNLOCK_KEY  = 12'h27c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_WIDTH   = 12'h280;
  localparam logic [ADDR_W-1:0] OFS_LINE_TEST   = 12'h284;
  localparam logic [ADDR_W-1:0] OFS_LOCK_STATUS = 12'h288;

  localparam logic [DATA_W-1:0] UNLOCK_KEY_VALUE = 16'haa37;
  localparam logic [DATA_W-1:0] IRQ_WIDTH_RESET  = 16'h001e;
  localparam logic [7:0]        LINE_TEST_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO        = 16'h0000;

  // ****************************************************************
  // line test fields
  // ****************************************************************
  localparam int unsigned TB_QUIET_NAK  = 0;
  localparam int unsigned TB_DRIVE_J    = 1;
  localparam int unsigned TB_DRIVE_K    = 2;
  localparam int unsigned TB_RANDOM     = 3;
  localparam int unsigned TB_LOCK_FS    = 4;
  localparam int unsigned TB_LOCK_HS    = 7;
  localparam int unsigned TEST_W        = 8;
  // bits that survive a usb bus reset
  localparam logic [7:0]  BUS_RESET_KEEP = 8'h90;

  localparam int unsigned LOCK_STATUS_BIT = 0;

  // ****************************************************************
  // pattern generator
  // ****************************************************************
  localparam int unsigned    RANDOM_TOGGLE_TEST_W    = 7;
  localparam logic [6:0]     RANDOM_TOGGLE_TEST_SEED = 7'h7f;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam real  CLK_PERIOD_NS      = 40.0;
  localparam real  IRQ_MIN_PULSE_NS   = 3.33;
  // least time rounds up, never below one cycle
  localparam int unsigned IRQ_MIN_CYCLES_RAW =
    int'($ceil(IRQ_MIN_PULSE_NS / CLK_PERIOD_NS));
  localparam int unsigned IRQ_MIN_CYCLES =
    (IRQ_MIN_CYCLES_RAW < 1) ? 1 : IRQ_MIN_CYCLES_RAW;

endpackage

// ===== hdl/uptu_irq_pulse.sv
// interrupt output shaper: level mode follows the request, pulse mode
// stretches each rising request to a programmed number of clock cycles
// assumes all inputs synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none

module uptu_irq_pulse
  import uptu_pkg::*;
#(
  parameter int unsigned WIDTH_W = 16
)
(
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               pulse_mode_in,
  input  wire logic               irq_req_in,
  input  wire logic [WIDTH_W-1:0] width_in,
  output logic                    irq_out
);

  logic [WIDTH_W-1:0] count_reg;
  logic [WIDTH_W-1:0] count_next;
  logic               req_d_reg;
  logic               req_d_next;
  logic               irq_reg;
  logic               irq_next;

  always_comb
  begin
    req_d_next = irq_req_in;
    count_next = count_reg;
    irq_next   = irq_reg;
    if (!pulse_mode_in)
    begin
      count_next = '0;
      irq_next   = irq_req_in;
    end
    else if (irq_req_in && !req_d_reg)
    begin
      // a zero width still gives the shortest pulse the clock allows
      count_next = (width_in < WIDTH_W'(IRQ_MIN_CYCLES)) ?
                   WIDTH_W'(IRQ_MIN_CYCLES) : width_in;
      irq_next   = 1'b1;
      count_next = count_next - WIDTH_W'(1);
    end
    else if (count_reg != '0)
    begin
      count_next = count_reg - WIDTH_W'(1);
      irq_next   = 1'b1;
    end
    else
    begin
      irq_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_reg <= '0;
      req_d_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      req_d_reg <= req_d_next;
      irq_reg   <= irq_next;
    end
  end

  assign irq_out = irq_reg;

endmodule

`default_nettype wire

// ===== hdl/uptu_line_pattern.sv
// pseudo-random line pattern source, x^7 + x^6 + 1 sequence
// restarts from the seed whenever it is disabled so the pattern is fixed
`timescale 1ns/1ps
`default_nettype none

module uptu_line_pattern
  import uptu_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic enable_in,
  output logic      bit_out
);

  logic [RANDOM_TOGGLE_TEST_W-1:0] lfsr_reg;
  logic [RANDOM_TOGGLE_TEST_W-1:0] lfsr_next;

  always_comb
  begin
    if (enable_in)
      lfsr_next = {lfsr_reg[RANDOM_TOGGLE_TEST_W-2:0], lfsr_reg[RANDOM_TOGGLE_TEST_W-1] ^ lfsr_reg[RANDOM_TOGGLE_TEST_W-2]};
    else
      lfsr_next = RANDOM_TOGGLE_TEST_SEED;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      lfsr_reg <= RANDOM_TOGGLE_TEST_SEED;
    else
      lfsr_reg <= lfsr_next;
  end

  assign bit_out = lfsr_reg[RANDOM_TOGGLE_TEST_W-1];

endmodule

`default_nettype wire

// ===== bench/uptu_regs_monitor.sv
// checker for the unlock, pulse width and line test register block
// assumes it is bound to uptu_regs and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none

module uptu_regs_monitor
  import uptu_pkg::*;
(
  input wire logic                core_clk_in,
  input wire logic                rst_in,
  input wire logic [uptu_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [uptu_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic                reg_wr_in,
  input wire logic                reg_rd_in,
  input wire logic [uptu_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic                resume_in,
  input wire logic                irq_pulse_mode_in,
  input wire logic                irq_req_in,
  input wire logic                irq_out,
  input wire logic                regs_writable_out,
  input wire logic                lock_high_speed_out,
  input wire logic                lock_full_speed_out,
  input wire logic                chirp_detect_en_out,
  input wire logic                line_dp_out,
  input wire logic                line_dm_out,
  input wire logic                line_oe_out,
  input wire logic                line_hs_idle_out,
  input wire logic                hs_in_token_in,
  input wire logic                force_nak_out,
  input wire logic                hs_quiet_nak_test_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence key_write;
    reg_wr_in && reg_addr_in == OFS_UNLOCK_KEY && reg_wdata_in == UNLOCK_KEY_VALUE;
  endsequence
  sequence req_rise;
    irq_pulse_mode_in && irq_req_in && !$past(irq_req_in);
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_LOCK_ON: assert property (resume_in |=> !regs_writable_out)
    else $error("writes still open after resume");
  AST_UNLOCK: assert property (key_write ##0 !resume_in |=> regs_writable_out)
    else $error("key write did not unlock");
  AST_LEVEL_IRQ: assert property (!irq_pulse_mode_in |=> irq_out == $past(irq_req_in))
    else $error("level interrupt does not follow request");
  AST_PULSE_START: assert property (req_rise |=> irq_out)
    else $error("pulse did not start after request");
  AST_CHIRP: assert property (chirp_detect_en_out
    == !(lock_high_speed_out || lock_full_speed_out))
    else $error("chirp detection wrong for speed lock");
  AST_NAK: assert property (force_nak_out
    == (hs_quiet_nak_test_out && hs_in_token_in))
    else $error("nak answer wrong");
  AST_IDLE_FOLLOW: assert property (line_hs_idle_out == $past(hs_quiet_nak_test_out))
    else $error("quiet line state not following test bit");
  AST_IDLE_LINES: assert property (line_hs_idle_out
    |-> !line_dp_out && !line_dm_out && line_oe_out)
    else $error("quiet state lines not driven low");
  AST_RD_ZERO: assert property (!reg_rd_in |=> reg_rdata_out == READ_ZERO)
    else $error("read data outside read cycle");
  AST_KEY_READ: assert property (reg_rd_in && reg_addr_in == OFS_UNLOCK_KEY
    |=> reg_rdata_out == READ_ZERO)
    else $error("key register readable");
endmodule

bind uptu_regs uptu_regs_monitor mon_u (.*);

`default_nettype wire

// ===== bench/uptu_host_model.sv
// usb host stand-in: issues high-speed in tokens while go_in is high
// and counts tokens and nak answers; assumes one core clock domain
`timescale 1ns/1ps
`default_nettype none

module uptu_host_model
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic go_in,
  input  wire logic force_nak_in,
  output logic      hs_in_token_out,
  output int        tok_count_out,
  output int        nak_count_out
);
  // tokens spaced by one idle cycle, as a host never sends them back to back
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hs_in_token_out <= 1'b0;
      tok_count_out   <= 0;
      nak_count_out   <= 0;
    end
    else
    begin
      hs_in_token_out <= go_in && !hs_in_token_out;
      tok_count_out   <= tok_count_out + int'(hs_in_token_out);
      nak_count_out   <= nak_count_out + int'(hs_in_token_out && force_nak_in);
    end
  end
endmodule

`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for uptu_regs with a host model on the token path
// assumes the design package is compiled first
`timescale 1ns/1ps
`default_nettype none

module tb;
  import uptu_pkg::*;
  logic              core_clk_in = 1'b0;
  logic              rst_in      = 1'b1;
  logic [ADDR_W-1:0] addr        = '0;
  logic [DATA_W-1:0] wdata       = '0;
  logic              wr          = 1'b0;
  logic              rd          = 1'b0;
  logic              resume      = 1'b0;
  logic              pmode       = 1'b0;
  logic              req         = 1'b0;
  logic              go          = 1'b0;
  logic              busrst      = 1'b0;
  logic [2:0]        xcvr        = 3'b110;
  logic [DATA_W-1:0] rdata;
  logic              irq, wren, lhs, lfs, chirp, dp, dm, oe, idle, tok, nak, quiet;
  int                toks, naks;
  int                mismatches  = 0;
  int                checked     = 0;

  always #20 core_clk_in = ~core_clk_in;

  uptu_regs dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .resume_in(resume), .usb_bus_reset_in(busrst), .irq_pulse_mode_in(pmode),
    .irq_req_in(req), .irq_out(irq), .regs_writable_out(wren),
    .lock_high_speed_out(lhs), .lock_full_speed_out(lfs), .chirp_detect_en_out(chirp),
    .xcvr_dp_in(xcvr[2]), .xcvr_dm_in(xcvr[1]), .xcvr_oe_in(xcvr[0]),
    .line_dp_out(dp), .line_dm_out(dm), .line_oe_out(oe), .line_hs_idle_out(idle),
    .hs_in_token_in(tok), .force_nak_out(nak), .hs_quiet_nak_test_out(quiet));

  uptu_host_model host_u (.clk_in(core_clk_in), .rst_in(rst_in), .go_in(go),
    .force_nak_in(nak), .hs_in_token_out(tok), .tok_count_out(toks),
    .nak_count_out(naks));

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
    @(posedge core_clk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk_in);
    rd <= 1'b0;
    @(negedge core_clk_in);
    chk(what, exp, rdata);
  endtask

  task automatic line_chk(input string what, input logic [3:0] exp);
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk(what, {12'h000, exp}, {12'h000, dp, dm, oe, idle});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk("width reset", OFS_IRQ_WIDTH, IRQ_WIDTH_RESET);
    rd_chk("test reset", OFS_LINE_TEST, 16'h0000);
    rd_chk("key reads zero", OFS_UNLOCK_KEY, 16'h0000);
    wr_reg(12'h2a0, 16'hffff);
    rd_chk("unmapped", 12'h2a0, 16'h0000);
    chk("chirp reset", 16'h0001, {15'h0000, chirp});
  endtask

  task automatic pulse_len(input string what, input logic [DATA_W-1:0] w,
                           input logic m, input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    wr_reg(OFS_IRQ_WIDTH, w);
    @(posedge core_clk_in);
    pmode <= m;
    req   <= 1'b1;
    repeat (12)
    begin
      @(negedge core_clk_in);
      n = n + {15'h0000, irq};
    end
    @(posedge core_clk_in);
    req <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    chk(what, exp, n);
  endtask

  task automatic t_irq();
    pulse_len("pulse width 3", 16'h0003, 1'b1, 16'h0003);
    pulse_len("pulse width 1", 16'h0001, 1'b1, 16'h0001);
    pulse_len("level mode", 16'h0001, 1'b0, 16'h000b);
  endtask

  task automatic t_lines();
    wr_reg(OFS_LINE_TEST, 16'h0001);
    line_chk("quiet lines", 4'b0011);
    wr_reg(OFS_LINE_TEST, 16'h0002);
    line_chk("j lines", 4'b1010);
    wr_reg(OFS_LINE_TEST, 16'h0004);
    line_chk("k lines", 4'b0110);
    wr_reg(OFS_LINE_TEST, 16'h0000);
    line_chk("normal lines", {xcvr, 1'b0});
    // a second transceiver drive shows the pass-through is not stuck
    @(posedge core_clk_in);
    xcvr <= 3'b001;
    line_chk("normal lines 2", 4'b0010);
  endtask

  task automatic collect(output logic [15:0] p, output logic diff);
    wr_reg(OFS_LINE_TEST, 16'h0008);
    diff = 1'b1;
    // line outputs follow the test register one clock later
    @(posedge core_clk_in);
    repeat (16)
    begin
      @(negedge core_clk_in);
      p = {p[14:0], dp};
      diff = diff & (dp ^ dm) & oe;
    end
    wr_reg(OFS_LINE_TEST, 16'h0000);
  endtask

  task automatic t_random();
    logic [15:0] a, b;
    logic        da, db;
    // the pattern must repeat exactly each time the test is entered
    collect(a, da);
    collect(b, db);
    chk("pattern repeat", a, b);
    chk("pattern toggles", 16'h0001, {15'h0000, a != 16'h0000 && a != 16'hffff});
    chk("pattern dm inverse", 16'h0001, {15'h0000, da & db});
  endtask

  task automatic t_speed();
    wr_reg(OFS_LINE_TEST, 16'h0080);
    line_chk("normal with hs lock", {xcvr, 1'b0});
    chk("hs lock", 16'h0002, {14'h0000, lhs, chirp});
    wr_reg(OFS_LINE_TEST, 16'h0010);
    @(negedge core_clk_in);
    chk("fs lock", 16'h0002, {13'h0000, lhs, lfs, chirp});
    wr_reg(OFS_LINE_TEST, 16'h0000);
    @(negedge core_clk_in);
    chk("no lock", 16'h0001, {13'h0000, lhs, lfs, chirp});
  endtask

  // usb bus reset keeps only the speed lock bits of the test register
  task automatic bus_rst(input string what, input logic [DATA_W-1:0] v,
                         input logic [DATA_W-1:0] exp);
    wr_reg(OFS_LINE_TEST, v);
    @(posedge core_clk_in);
    busrst <= 1'b1;
    @(posedge core_clk_in);
    busrst <= 1'b0;
    rd_chk(what, OFS_LINE_TEST, exp);
  endtask

  task automatic t_bus_reset();
    bus_rst("hs lock kept", 16'h0080, 16'h0080);
    bus_rst("random cleared", 16'h0008, 16'h0000);
  endtask

  task automatic run_host(output int dt, output int dn);
    int t0, n0;
    t0 = toks;
    n0 = naks;
    @(posedge core_clk_in);
    go <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    go <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    dt = toks - t0;
    dn = naks - n0;
  endtask

  task automatic t_nak();
    int dt, dn;
    wr_reg(OFS_LINE_TEST, 16'h0001);
    run_host(dt, dn);
    chk("nak count", 16'(dt), 16'(dn));
    chk("tokens sent", 16'h0001, {15'h0000, dt > 0});
    chk("quiet flag", 16'h0001, {15'h0000, quiet});
    wr_reg(OFS_LINE_TEST, 16'h0000);
    run_host(dt, dn);
    chk("nak after clear", 16'h0000, 16'(dn));
  endtask

  task automatic t_lock();
    @(posedge core_clk_in);
    resume <= 1'b1;
    @(posedge core_clk_in);
    resume <= 1'b0;
    rd_chk("locked", OFS_LOCK_STATUS, 16'h0001);
    chk("writes closed", 16'h0000, {15'h0000, wren});
    wr_reg(OFS_IRQ_WIDTH, 16'h0007);
    rd_chk("width kept", OFS_IRQ_WIDTH, 16'h0001);
    wr_reg(OFS_UNLOCK_KEY, 16'haa36);
    rd_chk("wrong key", OFS_LOCK_STATUS, 16'h0001);
    wr_reg(OFS_UNLOCK_KEY, UNLOCK_KEY_VALUE);
    rd_chk("unlocked", OFS_LOCK_STATUS, 16'h0000);
    chk("writes open", 16'h0001, {15'h0000, wren});
    wr_reg(OFS_IRQ_WIDTH, 16'h0007);
    rd_chk("width written", OFS_IRQ_WIDTH, 16'h0007);
  endtask

  // ****************************************************************
  // sequence and verdict
  // ****************************************************************
  task automatic end_of_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_irq();
    t_lines();
    t_random();
    t_speed();
    t_bus_reset();
    t_nak();
    t_lock();
    end_of_test();
  end

  // cuts a hang short well inside the cycle budget
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    mismatches++;
    end_of_test();
  end
endmodule

`default_nettype wire
